// ==== rtl/fpp_pkg.sv ====
// Purpose: Shared constants and types for the flash page program host
// Assumes: 10 MHz clock, 32K x 8 parallel flash with 64-byte pages
// Notes:   Protection and ID code sequences are parameters with plain defaults
package fpp_pkg;
  localparam int ClockHz        = 10_000_000;
  localparam int AddrW          = 15;
  localparam int DataW          = 8;
  localparam int PageBytes      = 64;
  localparam int PageLsb        = 6;
  localparam int CodeLen        = 3;
  // Byte load window in microseconds; the host aims well inside it
  localparam int ByteLoadUs     = 150;
  localparam int ByteLoadCyc    = (ByteLoadUs * (ClockHz / 1_000_000));
  // Write strobe low and high widths in ns (90 low, 100 high)
  localparam int WeLowNs        = 90;
  localparam int WeHighNs       = 100;
  localparam int WeLowCyc       = (WeLowNs * (ClockHz / 1_000_000) + 999) / 1000;
  localparam int WeHighCyc      = (WeHighNs * (ClockHz / 1_000_000) + 999) / 1000;
  // Output enable high pulse between toggle reads
  localparam int OeHighNs       = 150;
  localparam int OeHighCyc      = (OeHighNs * (ClockHz / 1_000_000) + 999) / 1000;
  // Read access wait before sampling
  localparam int ReadNs         = 150;
  localparam int ReadCyc        = (ReadNs * (ClockHz / 1_000_000) + 999) / 1000;
  localparam int TimerW         = 12;

  typedef enum logic [2:0] {
    FPP_CMD_PROGRAM  = 3'h0,
    FPP_CMD_PROT_ON  = 3'h1,
    FPP_CMD_PROT_OFF = 3'h2,
    FPP_CMD_ID_ENTER = 3'h3,
    FPP_CMD_ID_EXIT  = 3'h4,
    FPP_CMD_READ     = 3'h5
  } fpp_cmd_t;
endpackage

// ==== rtl/fpp_fifo.sv ====
// Purpose: Flop based FIFO for page data between user and sequencer
// Assumes: Single clock, registered storage addressed by index
// Notes:   Full and empty are exact; reading and writing together is allowed
module fpp_fifo #(
  parameter int Width = 8,
  parameter int Depth = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [Width-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [Width-1:0] outData
);
  localparam int PtrW = (Depth > 1) ? $clog2(Depth) : 1;

  // Refused at elaboration: fewer than two slots, or a width below one bit
  if (Depth < 2 || Width < 1) begin : gBadSize
    $error("fpp_fifo: unsupported size");
  end

  typedef struct packed {
    logic [Depth-1:0][Width-1:0] mem;
    logic [PtrW-1:0]             wrPtr;
    logic [PtrW-1:0]             rdPtr;
    logic [PtrW:0]               count;
  } fpp_fifo_t;

  fpp_fifo_t st_r;
  fpp_fifo_t st_nxt;
  logic      doWr;
  logic      doRd;

  function automatic logic [PtrW-1:0] bump(input logic [PtrW-1:0] p);
    bump = (p == PtrW'(Depth - 1)) ? '0 : p + 1'b1;
  endfunction

  assign inReady  = (st_r.count != (PtrW+1)'(Depth));
  assign outValid = (st_r.count != '0);
  assign outData  = st_r.mem[st_r.rdPtr];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always_comb begin
    st_nxt = st_r;
    if (doWr) begin
      st_nxt.mem[st_r.wrPtr] = inData;
      st_nxt.wrPtr           = bump(st_r.wrPtr);
    end
    if (doRd) begin
      st_nxt.rdPtr = bump(st_r.rdPtr);
    end
    case ({doWr, doRd})
      2'b10:   st_nxt.count = st_r.count + 1'b1;
      2'b01:   st_nxt.count = st_r.count - 1'b1;
      default: st_nxt.count = st_r.count;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ==== rtl/fpp_host.sv ====
// Purpose: Host sequencer driving a parallel page-programmed flash
// Assumes: Pins of the flash wired directly; 10 MHz clock; flash has no clock
// Notes:   One command at a time; data for a page arrives through a FIFO
// Notes on behaviour
// - Every byte of one page load presents the same page number bits.
// - Each byte load follows the previous within the byte load window only while the FIFO stays fed; an empty FIFO stalls it.
// - After a protection code, a full 64-byte page is loaded.
// - Toggle polling keeps one address; output enable toggles each read.
module fpp_host #(
  parameter int          FifoDepth = 8,
  parameter int          PollLimit = 200_000,
  parameter logic [14:0] CodeAddrA = 15'h5555,
  parameter logic [14:0] CodeAddrB = 15'h2aaa,
  parameter logic [7:0]  CodeDataA = 8'haa,
  parameter logic [7:0]  CodeDataB = 8'h55,
  // Third code bytes per command: arbitrary defaults
  parameter logic [7:0]  CodeProtOn  = 8'ha0,
  parameter logic [7:0]  CodeProtOff = 8'h20,
  parameter logic [7:0]  CodeIdEnter = 8'h90,
  parameter logic [7:0]  CodeIdExit  = 8'hf0
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  // Command
  input  wire logic                        cmdValid,
  output logic                             cmdReady,
  input  wire fpp_pkg::fpp_cmd_t           cmdOp,
  input  wire logic [fpp_pkg::AddrW-1:0]   cmdAddr,
  input  wire logic [6:0]                  cmdCount,
  // Page data stream
  input  wire logic                        dataValid,
  output logic                             dataReady,
  input  wire logic [fpp_pkg::DataW-1:0]   dataIn,
  // Result
  output logic                             doneValid,
  output logic                             doneError,
  output logic [fpp_pkg::DataW-1:0]        readData,
  // Flash pins
  output logic                             chipSel_n,
  output logic                             outEn_n,
  output logic                             writeStb_n,
  output logic [fpp_pkg::AddrW-1:0]        flashAddr,
  output logic [fpp_pkg::DataW-1:0]        flashDataOut,
  output logic                             flashDataOe,
  input  wire logic [fpp_pkg::DataW-1:0]   flashDataIn
);
  localparam int TW = fpp_pkg::TimerW;
  // Read wait also covers the three pin flops
  localparam int SyncCyc = 3;

  if (FifoDepth < 2 || PollLimit < 1) begin : gBadParam
    $error("fpp_host: bad parameter");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_CODE, S_WAIT, S_STB_LO, S_STB_HI, S_POLL_LO, S_POLL_HI, S_READ, S_DONE
  } fpp_state_t;

  typedef struct packed {
    fpp_state_t                  state;
    fpp_pkg::fpp_cmd_t           op;
    logic [1:0]                  codeIdx;
    logic [fpp_pkg::AddrW-1:0]   addr;
    logic [6:0]                  left;
    logic [TW-1:0]               timer;
    logic [31:0]                 polls;
    logic                        lastTgl;
    logic                        havePrev;
    logic                        inCode;
    logic                        cs_n;
    logic                        oe_n;
    logic                        we_n;
    logic [fpp_pkg::AddrW-1:0]   pinAddr;
    logic [fpp_pkg::DataW-1:0]   pinData;
    logic                        pinOe;
    logic                        done;
    logic                        err;
    logic [fpp_pkg::DataW-1:0]   rdData;
    logic [2:0][fpp_pkg::DataW-1:0] syncIn;
  } fpp_host_t;

  fpp_host_t                   st_r;
  fpp_host_t                   st_nxt;
  logic                        fifoValid;
  logic                        fifoPop;
  logic [fpp_pkg::DataW-1:0]   fifoData;
  logic [fpp_pkg::DataW-1:0]   pinSample;
  logic                        pinStable;

  fpp_fifo #(.Width(fpp_pkg::DataW), .Depth(FifoDepth)) u_fifo (
    .clock    (clock),
    .reset_n  (reset_n),
    .inValid  (dataValid),
    .inReady  (dataReady),
    .inData   (dataIn),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  function automatic logic [7:0] thirdCode(input fpp_pkg::fpp_cmd_t op);
    case (op)
      fpp_pkg::FPP_CMD_PROT_ON:  thirdCode = CodeProtOn;
      fpp_pkg::FPP_CMD_PROT_OFF: thirdCode = CodeProtOff;
      fpp_pkg::FPP_CMD_ID_ENTER: thirdCode = CodeIdEnter;
      default:                   thirdCode = CodeIdExit;
    endcase
  endfunction

  function automatic logic [TW-1:0] cyc(input int n);
    cyc = TW'(n);
  endfunction

  // Later stages agree: first stage feeds only the second
  assign pinSample = st_r.syncIn[2];
  assign pinStable = (st_r.syncIn[1] == st_r.syncIn[2]);
  assign cmdReady  = (st_r.state == S_IDLE);
  // Byte leaves the FIFO as it is placed on the data pins, a cycle before the strobe falls
  assign fifoPop   = (st_r.state == S_WAIT) && !st_r.inCode && fifoValid;

  assign chipSel_n    = st_r.cs_n;
  assign outEn_n      = st_r.oe_n;
  assign writeStb_n   = st_r.we_n;
  assign flashAddr    = st_r.pinAddr;
  assign flashDataOut = st_r.pinData;
  assign flashDataOe  = st_r.pinOe;
  assign doneValid    = st_r.done;
  assign doneError    = st_r.err;
  assign readData     = st_r.rdData;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.syncIn = {st_r.syncIn[1:0], flashDataIn};
    st_nxt.done   = 1'b0;
    if (st_r.timer != '0) st_nxt.timer = st_r.timer - 1'b1;
    case (st_r.state)
      S_IDLE: begin
        st_nxt.cs_n  = 1'b1;
        st_nxt.oe_n  = 1'b1;
        st_nxt.we_n  = 1'b1;
        st_nxt.pinOe = 1'b0;
        if (cmdValid) begin
          st_nxt.op       = cmdOp;
          st_nxt.addr     = cmdAddr;
          st_nxt.err      = 1'b0;
          st_nxt.codeIdx  = '0;
          st_nxt.havePrev = 1'b0;
          st_nxt.polls    = '0;
          // Protection codes are always followed by a full page
          if (cmdOp == fpp_pkg::FPP_CMD_PROT_ON || cmdOp == fpp_pkg::FPP_CMD_PROT_OFF) begin
            st_nxt.left = 7'(fpp_pkg::PageBytes);
          end else begin
            st_nxt.left = (cmdCount == '0) ? 7'h01 : cmdCount;
          end
          if (cmdOp == fpp_pkg::FPP_CMD_READ) begin
            st_nxt.cs_n    = 1'b0;
            st_nxt.oe_n    = 1'b0;
            st_nxt.pinAddr = cmdAddr;
            st_nxt.timer   = cyc(fpp_pkg::ReadCyc + SyncCyc);
            st_nxt.state   = S_READ;
          end else if (cmdOp == fpp_pkg::FPP_CMD_PROGRAM) begin
            st_nxt.inCode = 1'b0;
            st_nxt.state  = S_WAIT;
          end else begin
            st_nxt.inCode = 1'b1;
            st_nxt.state  = S_CODE;
          end
        end
      end
      S_CODE: begin
        case (st_r.codeIdx)
          2'h0: begin
            st_nxt.pinAddr = CodeAddrA;
            st_nxt.pinData = CodeDataA;
          end
          2'h1: begin
            st_nxt.pinAddr = CodeAddrB;
            st_nxt.pinData = CodeDataB;
          end
          default: begin
            st_nxt.pinAddr = CodeAddrA;
            st_nxt.pinData = thirdCode(st_r.op);
          end
        endcase
        st_nxt.state = S_STB_LO;
      end
      S_WAIT: begin
        // Stalls on an empty FIFO; keep it fed or the window lapses
        if (fifoValid) begin
          // Page number bits stay those of the command; only low bits step
          st_nxt.pinAddr = {st_r.addr[fpp_pkg::AddrW-1:fpp_pkg::PageLsb],
                            st_r.addr[fpp_pkg::PageLsb-1:0]};
          st_nxt.pinData = fifoData;
          st_nxt.state   = S_STB_LO;
        end
      end
      S_STB_LO: begin
        // Output enable held high before strobe goes low
        st_nxt.oe_n  = 1'b1;
        st_nxt.cs_n  = 1'b0;
        st_nxt.we_n  = 1'b0;
        st_nxt.pinOe = 1'b1;
        st_nxt.timer = cyc(fpp_pkg::WeLowCyc);
        st_nxt.state = S_STB_HI;
      end
      S_STB_HI: begin
        if (st_r.timer == '0) begin
          st_nxt.we_n  = 1'b1;
          st_nxt.cs_n  = 1'b1;
          st_nxt.timer = cyc(fpp_pkg::WeHighCyc);
          st_nxt.state = S_DONE;
        end
      end
      S_DONE: begin
        // Data released only after strobe has risen
        if (st_r.timer == '0) begin
          st_nxt.pinOe = 1'b0;
          if (st_r.inCode && st_r.codeIdx != 2'(fpp_pkg::CodeLen - 1)) begin
            st_nxt.codeIdx = st_r.codeIdx + 1'b1;
            st_nxt.state   = S_CODE;
          end else if (st_r.op == fpp_pkg::FPP_CMD_ID_ENTER ||
                       st_r.op == fpp_pkg::FPP_CMD_ID_EXIT) begin
            st_nxt.done  = 1'b1;
            st_nxt.state = S_IDLE;
          end else if (st_r.inCode || st_r.left != 7'h01) begin
            if (!st_r.inCode) begin
              st_nxt.left = st_r.left - 1'b1;
              st_nxt.addr = {st_r.addr[fpp_pkg::AddrW-1:fpp_pkg::PageLsb],
                             6'(st_r.addr[fpp_pkg::PageLsb-1:0] + 1'b1)};
            end
            st_nxt.inCode = 1'b0;
            st_nxt.state  = S_WAIT;
          end else begin
            // Protection change is only settled once this cycle ends
            st_nxt.state = S_POLL_LO;
          end
        end
      end
      S_POLL_LO: begin
        // Same address every read; each read is a fresh output enable pulse
        st_nxt.cs_n  = 1'b0;
        st_nxt.oe_n  = 1'b0;
        st_nxt.timer = cyc(fpp_pkg::ReadCyc + SyncCyc);
        st_nxt.state = S_POLL_HI;
      end
      S_POLL_HI: begin
        if (st_r.timer == '0 && pinStable) begin
          st_nxt.oe_n     = 1'b1;
          st_nxt.timer    = cyc(fpp_pkg::OeHighCyc);
          st_nxt.havePrev = 1'b1;
          st_nxt.lastTgl  = pinSample[6];
          st_nxt.polls    = st_r.polls + 1'b1;
          // Toggle level is meaningless; two equal toggle reads with bit 7 matching the written data end the wait
          if (st_r.havePrev && pinSample[6] == st_r.lastTgl &&
              pinSample[7] == st_r.pinData[7]) begin
            st_nxt.cs_n  = 1'b1;
            st_nxt.done  = 1'b1;
            st_nxt.state = S_IDLE;
          end else if (st_r.polls == 32'(PollLimit)) begin
            st_nxt.cs_n  = 1'b1;
            st_nxt.err   = 1'b1;
            st_nxt.done  = 1'b1;
            st_nxt.state = S_IDLE;
          end else begin
            st_nxt.state = S_READ;
          end
        end
      end
      S_READ: begin
        if (st_r.op == fpp_pkg::FPP_CMD_READ) begin
          // Maker or device code reads work the same way in ID mode
          if (st_r.timer == '0 && pinStable) begin
            st_nxt.rdData = pinSample;
            st_nxt.cs_n   = 1'b1;
            st_nxt.oe_n   = 1'b1;
            st_nxt.done   = 1'b1;
            st_nxt.state  = S_IDLE;
          end
        end else if (st_r.timer == '0) begin
          st_nxt.state = S_POLL_LO;
        end
      end
      default: st_nxt.state = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r       <= '0;
      st_r.state <= S_IDLE;
      st_r.cs_n  <= 1'b1;
      st_r.oe_n  <= 1'b1;
      st_r.we_n  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ==== dv/fpp_host_checker.sv ====
// Purpose: Concurrent checks on the flash pins of the page program host
// Assumes: Sees only the host's ports; one clock domain
// Notes:   Helper counters track writes and reads within one command
module fpp_host_checker (
  // Clock and reset
  input wire logic                      clock,
  input wire logic                      reset_n,
  // Command and result
  input wire logic                      cmdValid,
  input wire logic                      cmdReady,
  input wire fpp_pkg::fpp_cmd_t         cmdOp,
  input wire logic [fpp_pkg::AddrW-1:0] cmdAddr,
  input wire logic                      doneValid,
  input wire logic                      doneError,
  // Flash pins
  input wire logic                      chipSel_n,
  input wire logic                      outEn_n,
  input wire logic                      writeStb_n,
  input wire logic [fpp_pkg::AddrW-1:0] flashAddr,
  input wire logic                      flashDataOe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic              weQ;
  logic              haveRd;
  logic [7:0]        wrCnt;
  logic [8:0]        pageR;
  logic [11:0]       gap;
  logic [14:0]       rdA;
  logic [14:0]       cmdA;
  fpp_pkg::fpp_cmd_t opR;
  wire       take = cmdValid && cmdReady;
  wire       wf   = weQ && !writeStb_n && !chipSel_n;
  // Code writes come first for every command but a plain program or a read
  wire [7:0] base = (opR == fpp_pkg::FPP_CMD_PROGRAM) ? 8'h00 : 8'(fpp_pkg::CodeLen);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      weQ    <= 1'b1;
      haveRd <= 1'b0;
      wrCnt  <= 8'h00;
      pageR  <= 9'h000;
      gap    <= 12'h000;
      rdA    <= 15'h0000;
      cmdA   <= 15'h0000;
      opR    <= fpp_pkg::FPP_CMD_PROGRAM;
    end else begin
      weQ <= writeStb_n;
      gap <= (take || wf) ? 12'h000 : gap + {11'h000, gap != 12'hfff};
      if (take) begin
        wrCnt  <= 8'h00;
        opR    <= cmdOp;
        cmdA   <= cmdAddr;
        haveRd <= 1'b0;
      end else begin
        if (wf) wrCnt <= wrCnt + 8'h01;
        if (wf && wrCnt == base) pageR <= flashAddr[14:6];
        if (!outEn_n) begin
          haveRd <= 1'b1;
          rdA    <= flashAddr;
        end
      end
    end
  end
  sequence wrStart;
    wf;
  endsequence
  sequence rdStart;
    $fell(outEn_n) && !chipSel_n;
  endsequence
  oe_high_a: assert property (!chipSel_n && !writeStb_n |-> outEn_n)
    else $error("output enable low during a write");
  data_drive_a: assert property (!chipSel_n && !writeStb_n |-> flashDataOe)
    else $error("data not driven during a write");
  read_free_a: assert property (!outEn_n |-> !flashDataOe)
    else $error("data driven during a read");
  page_same_a: assert property (wrStart ##0 (wrCnt > base) |-> flashAddr[14:6] == pageR)
    else $error("page number changed within a page load");
  load_window_a: assert property (wrStart ##0 (wrCnt != 8'h00)
      |-> gap < 12'(fpp_pkg::ByteLoadCyc))
    else $error("byte load gap too long");
  full_page_a: assert property (doneValid && !doneError && (opR == fpp_pkg::FPP_CMD_PROT_ON
      || opR == fpp_pkg::FPP_CMD_PROT_OFF) |-> wrCnt == 8'(fpp_pkg::CodeLen + fpp_pkg::PageBytes))
    else $error("protection command did not load a full page");
  poll_addr_a: assert property (rdStart ##0 haveRd |-> flashAddr == rdA)
    else $error("polling address changed");
  read_addr_a: assert property (rdStart ##0 (opR == fpp_pkg::FPP_CMD_READ)
      |-> flashAddr == cmdA)
    else $error("read address differs from command");
  write_end_a: assert property (wrStart |-> ##[1:8] writeStb_n)
    else $error("write strobe held too long");
  done_pulse_a: assert property (doneValid |=> !doneValid && cmdReady)
    else $error("done not a single pulse");
endmodule

// ==== dv/fpp_flash_model.sv ====
// Purpose: Behavioural parallel flash facing the host
// Assumes: Pins driven by the host; no clock on this side
// Notes:   A read ends page loading; slow stretches the program cycle
module fpp_flash_model #(
  parameter logic [7:0] MakerCode = 8'h3c, // Arbitrary
  parameter logic [7:0] DevCode   = 8'h7e  // Arbitrary
) (
  // Host pins
  input  wire logic        chipSel_n,
  input  wire logic        outEn_n,
  input  wire logic        writeStb_n,
  input  wire logic [14:0] addr,
  input  wire logic [7:0]  dataIn,
  output logic      [7:0]  dataOut,
  // Bench control
  input  wire logic        slow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [32768];
  logic [14:0] ax0, ax1, ax2;
  logic [7:0]  d0, d1, d2, lastWr, lastOut, cur;
  logic        busy, tog, prot, armed, pendOn, pendOff, idMode;
  int          wcount;
  time         lastT, endT;
  wire rd = !chipSel_n && !outEn_n;
  wire wr = !chipSel_n && !writeStb_n;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    {busy, tog, prot, armed, pendOn, pendOff, idMode} = '0;
    {ax0, ax1, ax2, d0, d1, d2, lastWr, lastOut} = '0;
    wcount = 0;
    lastT = 0;
    endT = 0;
  end
  task automatic go;
    busy = 1'b1;
    wcount = 0;
    endT = $time + (slow ? 100_000 : 5_000);
  endtask
  always @(posedge wr) begin
    {ax2, ax1, ax0} = {ax1, ax0, addr};
    {d2, d1, d0} = {d1, d0, dataIn};
    // Unloaded bytes keep stale contents
    if (!busy && (!prot || armed)) begin
      mem[addr] = dataIn;
      lastWr = dataIn;
      wcount++;
      lastT = $time;
    end
    if (ax2 == 15'h5555 && d2 == 8'haa &&
        ax1 == 15'h2aaa && d1 == 8'h55 && ax0 == 15'h5555) begin
      case (d0)
        8'ha0: {armed, pendOn} = 2'b11;
        8'h20: {armed, pendOff} = 2'b11;
        8'h90: idMode = 1'b1;
        8'hf0: idMode = 1'b0;
        default: ;
      endcase
      if (d0 == 8'h90 || d0 == 8'hf0) wcount = 0;
    end
  end
  assign cur = (idMode && addr[14:1] == 14'h0000) ? (addr[0] ? DevCode : MakerCode)
             : busy ? {~lastWr[7], tog, 6'h15} : mem[addr];
  // Released bus shows no stale value
  assign dataOut = rd ? cur : ~lastOut;
  always @(negedge rd) lastOut = cur;
  always @(posedge rd) begin
    if (wcount > 0 && !busy) go();
    if (busy) tog = ~tog;
  end
  initial forever begin
    #50;
    if (wcount > 0 && !busy && $time - lastT > 3000) go();
    if (busy && $time >= endT) begin
      busy = 1'b0;
      if (pendOn) prot = 1'b1;
      if (pendOff) prot = 1'b0;
      {pendOn, pendOff, armed} = '0;
    end
  end
endmodule

// ==== dv/fpp_host_tb.sv ====
// Purpose: Self-checking bench for the flash page program host
// Assumes: Behavioural flash on the pins; poll limit shortened to 20
// Notes:   Inputs change 1 ns after the rising edge
module fpp_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MakerCode = 8'h3c; // Arbitrary
  localparam logic [7:0] DevCode   = 8'h7e; // Arbitrary
  logic              clock, reset_n, cmdValid, dataValid, slow, err;
  logic              cmdReady, dataReady, doneValid, doneError;
  logic              chipSel_n, outEn_n, writeStb_n, flashDataOe;
  fpp_pkg::fpp_cmd_t cmdOp;
  logic [14:0]       cmdAddr, flashAddr;
  logic [6:0]        cmdCount;
  logic [7:0]        dataIn, rdv, modelOut, readData, flashDataOut, busIn;
  int                nFail, cmpCount;
  assign busIn = flashDataOe ? flashDataOut : modelOut;
  fpp_host #(.PollLimit(20)) dut (.clock, .reset_n, .cmdValid, .cmdReady, .cmdOp, .cmdAddr,
    .cmdCount, .dataValid, .dataReady, .dataIn, .doneValid, .doneError, .readData, .chipSel_n,
    .outEn_n, .writeStb_n, .flashAddr, .flashDataOut, .flashDataOe, .flashDataIn(busIn));
  fpp_flash_model #(.MakerCode(MakerCode), .DevCode(DevCode)) flash (.chipSel_n, .outEn_n,
    .writeStb_n, .addr(flashAddr), .dataIn(flashDataOut), .dataOut(modelOut), .slow);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task reportAndStop;
    $display("compares %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task hang;
    nFail++;
    $display("mismatch at %0t: no answer", $time);
    reportAndStop();
  endtask
  task tick;
    @(posedge clock);
    #1;
  endtask
  task feed(input int n, input logic [7:0] b);
    int k;
    for (int i = 0; i < n; i++) begin
      dataValid = 1'b1;
      dataIn = b + 8'(i);
      k = 0;
      while (dataReady !== 1'b1) begin
        tick();
        if (++k > 3000) hang();
      end
      tick();
    end
    dataValid = 1'b0;
  endtask
  task run(input fpp_pkg::fpp_cmd_t op, input logic [14:0] a, input logic [6:0] c,
           input int n, input logic [7:0] b);
    int k;
    fork
      feed(n, b);
      begin
        {cmdValid, cmdOp, cmdAddr, cmdCount} = {1'b1, op, a, c};
        k = 0;
        while (cmdReady !== 1'b1) begin
          tick();
          if (++k > 3000) hang();
        end
        tick();
        cmdValid = 1'b0;
        k = 0;
        while (doneValid !== 1'b1) begin
          tick();
          if (++k > 5000) hang();
        end
        tick();
        err = doneError;
        rdv = readData;
      end
    join
  endtask
  task rdchk(input logic [14:0] a, input logic [7:0] exp);
    run(fpp_pkg::FPP_CMD_READ, a, 7'h00, 0, 8'h00);
    check(rdv, exp);
  endtask
  task tProgram;
    run(fpp_pkg::FPP_CMD_PROGRAM, 15'h00be, 7'h04, 4, 8'h31);
    check({7'h00, err}, 8'h00);
    for (int i = 0; i < 4; i++) rdchk({9'h002, 6'(62 + i)}, 8'h31 + 8'(i));
    $display("program test done");
  endtask
  task tProtect;
    feed(8, 8'h40);
    check({7'h00, dataReady}, 8'h00);
    // Let an edge pass so valid is not lowered and raised in one step
    tick();
    run(fpp_pkg::FPP_CMD_PROT_ON, 15'h0100, 7'h00, 56, 8'h48);
    check({7'h00, err}, 8'h00);
    rdchk(15'h013f, 8'h7f);
    run(fpp_pkg::FPP_CMD_PROGRAM, 15'h0200, 7'h01, 1, 8'h96);
    rdchk(15'h0200, 8'hff);
    run(fpp_pkg::FPP_CMD_PROT_OFF, 15'h0300, 7'h00, 64, 8'h00);
    rdchk(15'h033f, 8'h3f);
    run(fpp_pkg::FPP_CMD_PROGRAM, 15'h0200, 7'h01, 1, 8'h96);
    rdchk(15'h0200, 8'h96);
    $display("protect test done");
  endtask
  task tIdent;
    run(fpp_pkg::FPP_CMD_ID_ENTER, 15'h0000, 7'h00, 0, 8'h00);
    rdchk(15'h0000, MakerCode);
    rdchk(15'h0001, DevCode);
    run(fpp_pkg::FPP_CMD_ID_EXIT, 15'h0000, 7'h00, 0, 8'h00);
    rdchk(15'h0100, 8'h40);
    $display("ident test done");
  endtask
  task tSlow;
    slow = 1'b1;
    run(fpp_pkg::FPP_CMD_PROGRAM, 15'h0400, 7'h01, 1, 8'h5a);
    check({7'h00, err}, 8'h01);
    slow = 1'b0;
    // Let the long program cycle finish
    repeat (1100) tick();
    rdchk(15'h0400, 8'h5a);
    $display("slow test done");
  endtask
  initial begin
    {reset_n, cmdValid, dataValid, slow} = '0;
    {cmdOp, cmdAddr, cmdCount, dataIn} = '0;
    nFail = 0;
    cmpCount = 0;
    repeat (3) @(posedge clock);
    #1 reset_n = 1'b1;
    tProgram();
    tProtect();
    tIdent();
    tSlow();
    reportAndStop();
  end
endmodule
bind fpp_host fpp_host_checker chk (.clock, .reset_n, .cmdValid, .cmdReady, .cmdOp, .cmdAddr,
  .doneValid, .doneError, .chipSel_n, .outEn_n, .writeStb_n, .flashAddr, .flashDataOe);
